// >>> shared/grm_defs.svh
// Constants for the gigabit Ethernet rate match FIFO.
// Operation
// - The FIFO absorbs up to 200 ppm of combined clock offset without overflow or underflow.
// - No insertion or deletion starts before the word aligner reports synchronization.
// - Only whole K28.5/D16.2 idle sets are inserted or deleted, never a lone symbol.
// - Any number of such idle sets may be inserted or deleted to keep the fill in bounds.
// - Configuration sets led by K28.5/D2.2 may also be compensated, at a risk to negotiation.
// - Deletion events and insertion events are reported on two separate outputs.
// - Each deleted set and each inserted set holds its flag high for two clock cycles.
// - A removal that is not a whole number of sets is rounded up to whole sets.
`ifndef GRM_DEFS_SVH
`define GRM_DEFS_SVH
`define GRM_SYM_K28_5   8'hbc
`define GRM_SYM_D5_6    8'hc5
`define GRM_SYM_D16_2   8'h50
`define GRM_SYM_D2_2    8'h42
`define GRM_FIFO_DEPTH  16
`define GRM_FILL_HIGH   12
`define GRM_FILL_LOW    4
`define GRM_FLAG_CYCLES 2'd2
`define GRM_OFFSET_PPM  200
`endif

// >>> shared/grm_pkg.sv
// Types shared by the rate match FIFO design files.
package grm_pkg;
  typedef struct packed {
    logic       is_k;
    logic [7:0] code;
  } grm_sym_t;

  typedef enum logic [2:0] {
    GRM_RD_PASS  = 3'b001,
    GRM_RD_INS_K = 3'b010,
    GRM_RD_INS_D = 3'b100
  } grm_rd_state_t;
endpackage

// >>> design/grm_fifo.sv
// Single clock FIFO with valid/ready on both sides and a fill level output.
`timescale 1ns/1ns
`default_nettype none
module grm_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic                     clk,
  input  wire logic                     srst,
  input  wire logic                     ce,
  input  wire logic                     wr_valid,
  output logic                          wr_ready,
  input  wire logic [WIDTH-1:0]         wr_data,
  output logic                          rd_valid,
  input  wire logic                     rd_ready,
  output logic [WIDTH-1:0]              rd_data,
  output logic [$clog2(DEPTH):0]        level
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
    $error("grm_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic             push;
  logic             pop;

  assign wr_ready = (level != DEPTH[AW:0]);
  assign rd_valid = (level != '0);
  assign push     = wr_valid && wr_ready;
  assign pop      = rd_valid && rd_ready;
  assign rd_data  = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wr_ptr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else if (ce) begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        level <= level + 1'b1;
      end else if (pop && !push) begin
        level <= level - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> design/grm_rate_match.sv
// Receive rate match FIFO for gigabit Ethernet mode: idle set insertion and deletion.
`timescale 1ns/1ns
`default_nettype none
`include "grm_defs.svh"
module grm_rate_match #(
  parameter int DEPTH      = `GRM_FIFO_DEPTH,
  parameter int FILL_HIGH  = `GRM_FILL_HIGH,
  parameter int FILL_LOW   = `GRM_FILL_LOW,
  parameter bit CONFIG_CMP = 1'b0
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             ce,
  input  wire logic             gigabit_ethernet_mode,
  input  wire logic             sync_status,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire grm_pkg::grm_sym_t in_sym,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output grm_pkg::grm_sym_t     out_sym,
  output logic                  set_deleted,
  output logic                  set_inserted
);
  import grm_pkg::*;

  localparam int LW = $clog2(DEPTH) + 1;

  // The high and low marks must leave room for a whole set on either side of them.
  if (FILL_LOW < 2 || FILL_HIGH > DEPTH - 2 || FILL_LOW + 2 > FILL_HIGH) begin : g_bad
    $error("grm_rate_match: fill marks do not fit the FIFO depth");
  end

  // Compensation only runs in gigabit Ethernet mode once the aligner is synchronized.
  logic active;
  assign active = gigabit_ethernet_mode && sync_status;

  function automatic logic is_comma(input grm_sym_t s);
    is_comma = s.is_k && (s.code == `GRM_SYM_K28_5);
  endfunction

  // Second symbol of a set that may be compensated: D16.2 always, D2.2 only if allowed.
  function automatic logic is_second(input grm_sym_t s);
    is_second = !s.is_k && ((s.code == `GRM_SYM_D16_2) ||
                            (CONFIG_CMP && (s.code == `GRM_SYM_D2_2)));
  endfunction

  // FIFO between the aligned receive stream and the fabric side.
  logic          fifo_wr_valid;
  logic          fifo_wr_ready;
  grm_sym_t      fifo_wr_data;
  logic          fifo_rd_valid;
  logic          fifo_rd_ready;
  grm_sym_t      fifo_rd_data;
  logic [LW-1:0] fill;

  grm_fifo #(
    .WIDTH ($bits(grm_sym_t)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk      (clk),
    .srst     (srst),
    .ce       (ce),
    .wr_valid (fifo_wr_valid),
    .wr_ready (fifo_wr_ready),
    .wr_data  (fifo_wr_data),
    .rd_valid (fifo_rd_valid),
    .rd_ready (fifo_rd_ready),
    .rd_data  (fifo_rd_data),
    .level    (fill)
  );

  // Write side. One symbol is held back so that a comma can be dropped together with its
  // partner; a lone symbol is never removed. The hold costs one symbol of latency.
  logic     hold_valid;
  grm_sym_t hold_sym;
  logic     accept;
  logic     too_full;
  logic     drop_set;
  logic     take_hold;

  assign in_ready  = fifo_wr_ready;
  assign accept    = in_valid && in_ready;
  assign too_full  = (fill >= LW'(FILL_HIGH));
  // A set is dropped whole while the fill stays high, so any shortfall rounds up.
  assign drop_set  = accept && hold_valid && active && too_full &&
                     is_comma(hold_sym) && is_second(in_sym);
  assign take_hold = accept && !hold_valid && active && is_comma(in_sym);

  always_comb begin
    fifo_wr_valid = 1'b0;
    fifo_wr_data  = in_sym;
    if (accept) begin
      if (hold_valid) begin
        fifo_wr_valid = !drop_set;
        fifo_wr_data  = hold_sym;
      end else begin
        fifo_wr_valid = !take_hold;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      hold_valid <= 1'b0;
      hold_sym   <= '0;
    end else if (ce && accept) begin
      if (hold_valid) begin
        hold_valid <= !drop_set;
        hold_sym   <= in_sym;
      end else if (take_hold) begin
        hold_valid <= 1'b1;
        hold_sym   <= in_sym;
      end
    end
  end

  // Read side. An idle set is repeated only right after a whole set has gone out, so the
  // inserted pair never splits an ordered set or a frame.
  grm_rd_state_t rd_state;
  grm_rd_state_t next_rd_state;
  logic          load;
  logic          last_comma;
  logic          last_set_done;
  grm_sym_t      last_second;
  logic          too_empty;
  logic          start_ins;
  grm_sym_t      next_sym;
  logic          next_valid;

  assign load      = !out_valid || out_ready;
  assign too_empty = (fill <= LW'(FILL_LOW));
  assign start_ins = active && too_empty && last_set_done;

  always_comb begin
    next_rd_state = rd_state;
    fifo_rd_ready = 1'b0;
    next_valid    = 1'b0;
    next_sym      = fifo_rd_data;
    if (load) begin
      unique case (rd_state)
        GRM_RD_PASS: begin
          if (start_ins) begin
            next_valid    = 1'b1;
            next_sym      = grm_sym_t'{is_k: 1'b1, code: `GRM_SYM_K28_5};
            next_rd_state = GRM_RD_INS_D;
          end else begin
            fifo_rd_ready = 1'b1;
            next_valid    = fifo_rd_valid;
          end
        end
        GRM_RD_INS_D: begin
          next_valid    = 1'b1;
          next_sym      = last_second;
          next_rd_state = GRM_RD_PASS;
        end
        default: begin
          next_rd_state = GRM_RD_PASS;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_state <= GRM_RD_PASS;
    end else if (ce) begin
      rd_state <= next_rd_state;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      out_valid <= 1'b0;
      out_sym   <= '0;
    end else if (ce && load) begin
      out_valid <= next_valid;
      if (next_valid) begin
        out_sym <= next_sym;
      end
    end
  end

  // Track the last symbols handed on, to know when a whole set has just gone out.
  always_ff @(posedge clk) begin
    if (srst) begin
      last_comma    <= 1'b0;
      last_set_done <= 1'b0;
      last_second   <= '0;
    end else if (ce && load && next_valid) begin
      last_comma    <= is_comma(next_sym);
      last_set_done <= last_comma && is_second(next_sym);
      if (last_comma && is_second(next_sym)) begin
        last_second <= next_sym;
      end
    end
  end

  // Event flags: each set reloads a two cycle stretch, so back to back sets keep it high.
  logic [1:0] del_count;
  logic [1:0] ins_count;
  logic       ins_event;

  assign ins_event = ce && load && (rd_state == GRM_RD_PASS) && start_ins;

  // The flags are registers beside their counters; srst clears them without the enable, the clear on loss of sync waits for it.
  always_ff @(posedge clk) begin
    if (srst) begin
      del_count   <= '0;
      set_deleted <= 1'b0;
    end else if (ce) begin
      if (!active) begin
        del_count   <= '0;
        set_deleted <= 1'b0;
      end else if (drop_set) begin
        del_count   <= `GRM_FLAG_CYCLES;
        set_deleted <= 1'b1;
      end else if (del_count != '0) begin
        del_count   <= del_count - 1'b1;
        set_deleted <= (del_count > 2'd1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ins_count    <= '0;
      set_inserted <= 1'b0;
    end else if (ce) begin
      if (!active) begin
        ins_count    <= '0;
        set_inserted <= 1'b0;
      end else if (ins_event) begin
        ins_count    <= `GRM_FLAG_CYCLES;
        set_inserted <= 1'b1;
      end else if (ins_count != '0) begin
        ins_count    <= ins_count - 1'b1;
        set_inserted <= (ins_count > 2'd1);
      end
    end
  end

  // A 16 word FIFO with marks at 4 and 12 leaves ample slack: at 200 ppm one set must be
  // compensated only about every 10000 symbols, far slower than sets arrive in idle gaps.
endmodule
`default_nettype wire

// >>> tb/grm_rate_match_asserts.sv
// Port checker for the rate match FIFO.
`timescale 1ns/1ns
`default_nettype none
`include "grm_defs.svh"
module grm_rate_match_asserts (
  input wire logic              clk,
  input wire logic              srst,
  input wire logic              ce,
  input wire logic              sync_status,
  input wire logic              in_valid,
  input wire logic              in_ready,
  input wire grm_pkg::grm_sym_t in_sym,
  input wire logic              out_valid,
  input wire logic              out_ready,
  input wire grm_pkg::grm_sym_t out_sym,
  input wire logic              set_deleted,
  input wire logic              set_inserted
);
  import grm_pkg::*;
  logic last_k;
  always_ff @(posedge clk) begin
    if (srst) begin
      last_k <= 1'b0;
    end else if (ce && out_valid && out_ready) begin
      last_k <= out_sym.is_k;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_unsync_quiet: assert property (
    (!sync_status && ce) [*2] |-> !set_deleted && !set_inserted)
    else $error("event flag without sync");
  a_evt_after_sync: assert property (
    $rose(set_deleted) || $rose(set_inserted) |-> $past(sync_status))
    else $error("event before sync");
  a_del_hold: assert property ($rose(set_deleted) |=> set_deleted)
    else $error("deletion flag too short");
  a_ins_hold: assert property ($rose(set_inserted) |=> set_inserted)
    else $error("insertion flag too short");
  a_flags_apart: assert property (!(set_deleted && set_inserted))
    else $error("both event flags high");
  a_ins_k_first: assert property (
    $rose(set_inserted) |-> out_valid && out_sym == {1'b1, `GRM_SYM_K28_5})
    else $error("insertion does not start with comma");
  a_ins_second: assert property (
    $rose(set_inserted) && ce && out_ready |=> out_valid && !out_sym.is_k)
    else $error("inserted set not whole");
  a_del_cause: assert property (
    $rose(set_deleted) |-> $past(in_valid && in_ready) && !$past(in_sym.is_k) &&
      $past(in_sym, 2) == {1'b1, `GRM_SYM_K28_5})
    else $error("deletion without a whole set");
  a_no_lone_k: assert property (
    ce && out_valid && out_ready && last_k |-> !out_sym.is_k)
    else $error("comma sent without its partner");
  // A flag may only stand while the set that raised it is at most two cycles old.
  a_del_recent: assert property (
    set_deleted |-> $past(in_valid && in_ready && !in_sym.is_k) ||
      $past(in_valid && in_ready && !in_sym.is_k, 2))
    else $error("deletion flag held too long");
  a_ins_recent: assert property (
    set_inserted |-> out_sym == {1'b1, `GRM_SYM_K28_5} ||
      $past(out_sym) == {1'b1, `GRM_SYM_K28_5})
    else $error("insertion flag held too long");
  c_del: cover property ($rose(set_deleted));
  c_ins: cover property ($rose(set_inserted));
  c_full: cover property (in_valid && !in_ready);
endmodule
bind grm_rate_match grm_rate_match_asserts grm_rate_match_asserts_inst (.clk(clk), .srst(srst),
  .ce(ce),
  .sync_status(sync_status), .in_valid(in_valid), .in_ready(in_ready), .in_sym(in_sym),
  .out_valid(out_valid), .out_ready(out_ready), .out_sym(out_sym), .set_deleted(set_deleted),
  .set_inserted(set_inserted));
`default_nettype wire

// >>> tb/grm_link_model.sv
// Remote link transmitter model: data counts, idle ordered sets or configuration sets.
`timescale 1ns/1ns
`default_nettype none
`include "grm_defs.svh"
module grm_link_model (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         en,
  input  wire logic         slow,
  input  wire logic [1:0]   kind,
  input  wire logic         ready,
  output logic              valid,
  output grm_pkg::grm_sym_t sym
);
  import grm_pkg::*;
  logic [7:0] cnt;
  logic       gap;
  // Released symbol lines toggle so that a stale word never looks valid.
  always_ff @(posedge clk) begin
    if (srst) begin
      valid <= 1'b0;
      cnt <= 8'h00;
      gap <= 1'b0;
      sym <= '0;
    end else if (!valid || ready) begin
      gap <= !gap;
      if (en && (!slow || gap)) begin
        valid <= 1'b1;
        cnt <= cnt + 8'h01;
        if (kind == 2'd0) sym <= {1'b0, cnt};
        else if (!cnt[0]) sym <= {1'b1, `GRM_SYM_K28_5};
        else if (kind == 2'd2) sym <= {1'b0, `GRM_SYM_D2_2};
        else if (kind == 2'd3 && cnt[1]) sym <= {1'b0, `GRM_SYM_D5_6};
        else sym <= {1'b0, `GRM_SYM_D16_2};
      end else begin
        valid <= 1'b0;
        sym <= ~sym;
        if (!en) cnt <= 8'h00;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the rate match FIFO against a link transmitter model.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import grm_pkg::*;
  typedef struct packed {
    logic       sync, mode, slow, ordy;
    logic [1:0] kind;
    logic       del, ins, full;
  } grm_row_t;
  // Fields: sync, mode, slow, out_ready, kind; then deletion, insertion, refusal seen.
  grm_row_t   rows [7] = '{9'b0_1_0_0_01_0_0_1, 9'b1_1_0_0_01_1_0_0, 9'b1_1_1_1_11_0_1_0,
                           9'b1_0_0_0_01_0_0_1, 9'b1_1_0_0_10_0_0_1, 9'b1_1_0_0_00_0_0_1,
                           9'b0_1_1_1_11_0_0_0};
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic       sync = 1'b0, mode = 1'b0, slow = 1'b0, ordy = 1'b0, en = 1'b0;
  logic       ce = 1'b1;
  logic [1:0] kind = 2'd0;
  logic       in_valid, in_ready, out_valid, set_deleted, set_inserted;
  grm_sym_t   in_sym, out_sym;
  grm_sym_t   q[$];
  int         ndel, nins, nfull, miscompares, n_checks, cycles;

  always #10 clk = ~clk;

  grm_rate_match grm_rate_match_inst (.clk(clk), .srst(srst), .ce(ce),
    .gigabit_ethernet_mode(mode), .sync_status(sync), .in_valid(in_valid), .in_ready(in_ready),
    .in_sym(in_sym), .out_valid(out_valid), .out_ready(ordy), .out_sym(out_sym),
    .set_deleted(set_deleted), .set_inserted(set_inserted));
  grm_link_model grm_link_model_inst (.clk(clk), .srst(srst), .en(en), .slow(slow),
    .kind(kind), .ready(in_ready), .valid(in_valid), .sym(in_sym));

  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic run_row(input grm_row_t r);
    @(posedge clk);
    srst <= 1'b1;
    en <= 1'b0;
    @(posedge clk);
    srst <= 1'b0;
    q.delete();
    {sync, mode, slow, ordy, kind} <= {r.sync, r.mode, r.slow, r.ordy, r.kind};
    en <= 1'b1;
    #1;
    check("out_valid", {8'h00, out_valid}, 9'h000);
    check("flags", {7'h00, set_deleted, set_inserted}, 9'h000);
    check("in_ready", {8'h00, in_ready}, 9'h001);
    repeat (150) @(posedge clk);
    en <= 1'b0;
  endtask

  // The ceiling is over twice the planned run of about 1270 cycles, so only a real hang reaches it.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      close_out;
    end
    if (srst) begin
      ndel <= 0;
      nins <= 0;
      nfull <= 0;
    end else begin
      ndel <= ndel + int'(set_deleted);
      nins <= nins + int'(set_inserted);
      nfull <= nfull + int'(in_valid && !in_ready);
      if (out_valid && ordy && ce) q.push_back(out_sym);
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    foreach (rows[i]) begin
      run_row(rows[i]);
      check("deleted", {8'h00, ndel != 0}, {8'h00, rows[i].del});
      check("inserted", {8'h00, nins != 0}, {8'h00, rows[i].ins});
      check("refused", {8'h00, nfull != 0}, {8'h00, rows[i].full});
      $display("row %0d done", i);
    end
    // The first 16 words stored while the fabric stalls must later come out whole and in order.
    run_row(9'b0_1_0_0_00_0_0_1);
    // With the enable low nothing may move, even with the fabric ready to take words.
    ce <= 1'b0;
    ordy <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    check("frozen_sym", out_sym, 9'h000);
    check("frozen_taken", 9'(q.size()), 9'h000);
    @(posedge clk);
    ce <= 1'b1;
    repeat (40) @(posedge clk);
    for (int i = 0; i < 16; i++) check("order", q[i], {1'b0, 8'(i)});
    $display("order test done");
    close_out;
  end
endmodule
`default_nettype wire
